// file: design/abscc_fifo.sv
`timescale 1ns/1ps
module abscc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic rdy;
	} abscc_fifo_s;
	abscc_fifo_s s_q, s_d;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic push, pop;
	assign in_ready_out = s_q.rdy;
	assign out_valid_out = (s_q.cnt != '0);
	assign out_data_out = mem_q[s_q.rp];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.wp = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + 1'b1;
		end
		if (pop) begin
			s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + 1'b1;
		end
		s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		// registered not-full flag
		s_d.rdy = (s_d.cnt != (AW+1)'(DEPTH));
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
		if (push) begin
			mem_q[s_q.wp] <= in_data_in;
		end
	end
endmodule

// file: design/abscc_pkg.sv
//------------------------------------------------------------
// Function
// - read-only half flag shows buffer half filling
// - fill mode set alternates halves per interrupt
// - fill mode clear restarts at location zero
// - count field plus one operations per increment
// - channel count selects one, two, four channels
// - resolution bit picks twelve-bit single channel
// - build mode picks conversion-order or scatter address
//------------------------------------------------------------
package abscc_pkg;
	// register offsets
	localparam logic [3:0] ADDR_CTRL_TWO = 4'h0;
	localparam logic [3:0] ADDR_CTRL_ONE = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	// field positions in converter_control_two
	localparam int REF_LSB = 13;
	localparam int SCAN_BIT = 10;
	localparam int CHAN_LSB = 8;
	localparam int HALF_BIT = 7;
	localparam int OPS_LSB = 2;
	localparam int FILL_BIT = 1;
	localparam int ALT_BIT = 0;
	// field positions in companion control register
	localparam int BUILD_BIT = 12;
	localparam int RES_BIT = 10;
	// reset values
	localparam logic [15:0] CTRL_TWO_RST = 16'h0000;
	localparam logic [15:0] CTRL_ONE_RST = 16'h0000;
	// writable masks
	localparam logic [15:0] CTRL_TWO_WMASK = 16'he73f;
	localparam logic [15:0] CTRL_ONE_WMASK = 16'h1400;
	// buffer depth in words and fifo depth
	localparam int BUF_DEPTH = 16;
	localparam int FIFO_DEPTH = 8;
endpackage

// file: design/abscc_top.sv
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module abscc_top #(
	parameter int DATA_W = 16
) (
	// clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic RST_IN,
	// register port
	input wire logic [3:0] REG_ADDR_IN,
	input wire logic [15:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	output logic [15:0] REG_RDATA_OUT,
	// converter core results
	input wire logic CONV_VALID_IN,
	output logic CONV_READY_OUT,
	input wire logic [DATA_W-1:0] CONV_DATA_IN,
	// converter core configuration
	output logic [1:0] CHAN_ENABLE_SEL_OUT,
	output logic REF_POS_EXT_OUT,
	output logic REF_NEG_EXT_OUT,
	output logic SCAN_EN_OUT,
	output logic RES_12BIT_OUT,
	// dma side
	output logic DMA_VALID_OUT,
	input wire logic DMA_READY_IN,
	output logic [DATA_W-1:0] DMA_DATA_OUT,
	output logic [3:0] DMA_ADDR_OUT,
	output logic DMA_INCR_OUT,
	output logic BLOCK_IRQ_OUT
);
	typedef struct packed {
		logic [15:0] ctl2;
		logic [15:0] ctl1;
		logic half;
		logic [3:0] ops;
		logic [3:0] pos;
		logic [15:0] rdata;
		logic dv;
		logic [DATA_W-1:0] dd;
		logic [3:0] da;
		logic incr;
		logic irq;
		logic [1:0] chsel;
		logic rpos, rneg, scan, res;
	} abscc_top_s;
	abscc_top_s s_q, s_d;
	logic f_valid, f_ready;
	logic [DATA_W-1:0] f_data;
	logic take;
	logic [3:0] ops_lim;
	logic [15:0] ctl2_view;

	//------------------------------------------------------------
	// result fifo
	//------------------------------------------------------------
	abscc_fifo #(.WIDTH(DATA_W), .DEPTH(abscc_pkg::FIFO_DEPTH)) u_fifo (
		.clk_in(CORE_CLK_IN),
		.rst_in(RST_IN),
		.in_valid_in(CONV_VALID_IN),
		.in_ready_out(CONV_READY_OUT),
		.in_data_in(CONV_DATA_IN),
		.out_valid_out(f_valid),
		.out_ready_in(f_ready),
		.out_data_out(f_data)
	);
	// stall when the dma has not taken the last word
	assign f_ready = !s_q.dv || DMA_READY_IN;
	assign take = f_valid && f_ready;
	assign ops_lim = s_q.ctl2[abscc_pkg::OPS_LSB +: 4];

	//------------------------------------------------------------
	// register read view
	//------------------------------------------------------------
	always_comb begin
		ctl2_view = s_q.ctl2 & abscc_pkg::CTRL_TWO_WMASK;
		ctl2_view[abscc_pkg::HALF_BIT] = s_q.half;
		if (s_q.ctl1[abscc_pkg::RES_BIT]) begin
			ctl2_view[abscc_pkg::CHAN_LSB +: 2] = 2'h0;
		end
	end

	//------------------------------------------------------------
	// next state
	//------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.incr = 1'b0;
		s_d.irq = 1'b0;
		s_d.rdata = 16'h0000;
		if (REG_WR_IN) begin
			if (REG_ADDR_IN == abscc_pkg::ADDR_CTRL_TWO) begin
				s_d.ctl2 = REG_WDATA_IN & abscc_pkg::CTRL_TWO_WMASK;
			end else if (REG_ADDR_IN == abscc_pkg::ADDR_CTRL_ONE) begin
				s_d.ctl1 = REG_WDATA_IN & abscc_pkg::CTRL_ONE_WMASK;
			end
		end
		if (REG_RD_IN) begin
			case (REG_ADDR_IN)
				abscc_pkg::ADDR_CTRL_TWO: s_d.rdata = ctl2_view;
				abscc_pkg::ADDR_CTRL_ONE: s_d.rdata = s_q.ctl1;
				abscc_pkg::ADDR_STATUS: s_d.rdata = {8'h00, s_q.ops, s_q.pos};
				default: s_d.rdata = 16'h0000;
			endcase
		end
		if (s_q.dv && DMA_READY_IN) begin
			s_d.dv = 1'b0;
		end
		if (take) begin
			s_d.dv = 1'b1;
			s_d.dd = f_data;
			if (s_q.ctl1[abscc_pkg::BUILD_BIT]) begin
				// conversion order, same as stand-alone buffer
				s_d.da = s_q.pos;
			end else begin
				// scatter: channel index times block size, plus pos shifted right by two
				s_d.da = 4'((s_q.pos & 4'h3) * (ops_lim + 4'h1)
					+ (s_q.pos >> 2));
			end
			s_d.pos = s_q.pos + 4'h1;
			if (s_q.ops == ops_lim) begin
				s_d.ops = 4'h0;
				s_d.incr = 1'b1;
				s_d.irq = 1'b1;
				if (s_q.ctl2[abscc_pkg::FILL_BIT]) begin
					s_d.half = !s_q.half;
					s_d.pos = s_q.half ? 4'h0 : 4'h8;
				end else begin
					s_d.half = 1'b0;
					s_d.pos = 4'h0;
				end
			end else begin
				s_d.ops = s_q.ops + 4'h1;
			end
		end
		// core configuration
		s_d.res = s_q.ctl1[abscc_pkg::RES_BIT];
		s_d.scan = s_q.ctl2[abscc_pkg::SCAN_BIT];
		s_d.chsel = s_q.ctl1[abscc_pkg::RES_BIT] ? 2'h0
			: s_q.ctl2[abscc_pkg::CHAN_LSB +: 2];
		s_d.rpos = !s_q.ctl2[15] && s_q.ctl2[13];
		s_d.rneg = !s_q.ctl2[15] && s_q.ctl2[14];
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	//------------------------------------------------------------
	// outputs
	//------------------------------------------------------------
	assign REG_RDATA_OUT = s_q.rdata;
	assign CHAN_ENABLE_SEL_OUT = s_q.chsel;
	assign REF_POS_EXT_OUT = s_q.rpos;
	assign REF_NEG_EXT_OUT = s_q.rneg;
	assign SCAN_EN_OUT = s_q.scan;
	assign RES_12BIT_OUT = s_q.res;
	assign DMA_VALID_OUT = s_q.dv;
	assign DMA_DATA_OUT = s_q.dd;
	assign DMA_ADDR_OUT = s_q.da;
	assign DMA_INCR_OUT = s_q.incr;
	assign BLOCK_IRQ_OUT = s_q.irq;
endmodule

// file: tb/abscc_partner.sv
`timescale 1ns/1ps
module abscc_partner (
	input wire logic clk_in, rst_in, go_in, stall_in, conv_ready_in,
	input wire logic [3:0] words_in,
	output logic conv_valid_out, dma_ready_out,
	output logic [15:0] conv_data_out
);
	logic [3:0] left;
	logic [15:0] cnt;
	// core: sends a quota of counting words
	assign conv_valid_out = left != 4'h0;
	assign conv_data_out = conv_valid_out ? cnt : ~cnt;
	assign dma_ready_out = !stall_in;
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			left <= 4'h0;
			cnt <= 16'h0;
		end else if (go_in) begin
			left <= words_in;
		end else if (conv_valid_out && conv_ready_in) begin
			left <= left - 4'h1;
			cnt <= cnt + 16'h1;
		end
	end
endmodule

// file: tb/abscc_properties.sv
`timescale 1ns/1ps
module abscc_checker #(parameter int DATA_W = 16) (
	input wire logic CORE_CLK_IN, RST_IN, REG_WR_IN, REG_RD_IN,
	input wire logic [3:0] REG_ADDR_IN, DMA_ADDR_OUT,
	input wire logic [15:0] REG_WDATA_IN, REG_RDATA_OUT,
	input wire logic [1:0] CHAN_ENABLE_SEL_OUT,
	input wire logic REF_POS_EXT_OUT, REF_NEG_EXT_OUT, RES_12BIT_OUT,
	input wire logic DMA_VALID_OUT, DMA_READY_IN, DMA_INCR_OUT,
	input wire logic BLOCK_IRQ_OUT,
	input wire logic [DATA_W-1:0] DMA_DATA_OUT
);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (RST_IN);
	irq_with_incr_a: assert property (BLOCK_IRQ_OUT == DMA_INCR_OUT)
		else $error("irq apart from incr");
	incr_on_word_a: assert property (DMA_INCR_OUT |-> DMA_VALID_OUT)
		else $error("incr without word");
	word_hold_a: assert property (DMA_VALID_OUT && !DMA_READY_IN |=>
		DMA_VALID_OUT && $stable(DMA_ADDR_OUT) && $stable(DMA_DATA_OUT))
		else $error("word dropped");
	chan_forced_a: assert property (RES_12BIT_OUT |-> !CHAN_ENABLE_SEL_OUT)
		else $error("channels in 12-bit");
	rd_gaps_a: assert property (REG_RD_IN && REG_ADDR_IN == 4'h0 |=>
		!REG_RDATA_OUT[6] && REG_RDATA_OUT[12:11] == 2'h0)
		else $error("gap bits set");
	ref_code_a: assert property (REG_WR_IN && REG_ADDR_IN == 4'h0 |-> ##2
		{REF_NEG_EXT_OUT, REF_POS_EXT_OUT} == ($past(REG_WDATA_IN[15], 2) ?
		2'h0 : $past(REG_WDATA_IN[14:13], 2))) else $error("reference");
	res_follow_a: assert property (REG_WR_IN && REG_ADDR_IN == 4'h1 |-> ##2
		RES_12BIT_OUT == $past(REG_WDATA_IN[10], 2)) else $error("resolution");
endmodule
bind abscc_top abscc_checker #(.DATA_W(DATA_W)) abscc_checker_inst (.*);

// file: tb/tb_adc_buffer_sequence_control.sv
`timescale 1ns/1ps
module tb_adc_buffer_sequence_control;
	logic clk = 0, rst = 1, wr = 0, rd = 0, go = 0, stall = 0;
	logic [3:0] addr = 4'h0, words = 4'h0, daddr;
	logic [15:0] wdata = 16'h0, rdata, cdata, ddata;
	logic cvalid, cready, dvalid, dready, incr, pos, neg, res, irq, scan;
	logic [1:0] chan;
	logic [15:0] nxt = 16'h0;
	logic [5:0] seen[$];
	logic [4:0] want[15] = '{5'h0, 5'h1, 5'h2, 5'h13, 5'h8, 5'h9, 5'ha,
		5'h1b, 5'h10, 5'h10, 5'h10, 5'h0, 5'h4, 5'h8, 5'h1c};
	int err_total = 0, checks_done = 0;
	always #20 clk = ~clk;
	abscc_top abscc_top_inst (.CORE_CLK_IN(clk), .RST_IN(rst),
		.REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr),
		.REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .CONV_VALID_IN(cvalid),
		.CONV_READY_OUT(cready), .CONV_DATA_IN(cdata),
		.CHAN_ENABLE_SEL_OUT(chan), .REF_POS_EXT_OUT(pos),
		.REF_NEG_EXT_OUT(neg), .SCAN_EN_OUT(scan), .RES_12BIT_OUT(res),
		.DMA_VALID_OUT(dvalid), .DMA_READY_IN(dready), .DMA_DATA_OUT(ddata),
		.DMA_ADDR_OUT(daddr), .DMA_INCR_OUT(incr), .BLOCK_IRQ_OUT(irq));
	abscc_partner abscc_partner_inst (.clk_in(clk), .rst_in(rst), .go_in(go),
		.words_in(words), .stall_in(stall), .conv_ready_in(cready),
		.conv_valid_out(cvalid), .conv_data_out(cdata), .dma_ready_out(dready));
	always @(posedge clk) begin
		if (dvalid && dready) begin
			seen.push_back({irq, incr, daddr});
			chk("data", nxt, ddata);
			nxt <= nxt + 16'h1;
		end
	end
	task automatic chk(string n, logic [15:0] e, s);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic acc(logic w, logic [3:0] a, logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1 if (!w) chk("reg", d, rdata);
	endtask
	task automatic drain(int tot);
		for (int i = 0; i < 99 && seen.size() < tot; i++) @(posedge clk);
		if (seen.size() < tot) begin
			err_total++;
			$display("MISMATCH drain exp %0d got %0d", tot, seen.size());
		end
	endtask
	task automatic feed(logic [3:0] n, int tot);
		@(posedge clk);
		go <= 1'b1;
		words <= n;
		@(posedge clk);
		go <= 1'b0;
		drain(tot);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		acc(0, 4'h0, 16'h0);
		acc(0, 4'h1, 16'h0);
		acc(1, 4'hf, 16'hffff);
		acc(0, 4'hf, 16'h0);
		acc(1, 4'h0, 16'hffff);
		acc(0, 4'h0, 16'he73f);
		chk("cfg", 16'h23, {scan, pos, neg, res, chan});
		acc(1, 4'h1, 16'h0400);
		acc(0, 4'h0, 16'he43f);
		chk("cfg", 16'h24, {scan, pos, neg, res, chan});
		acc(1, 4'h1, 16'h1000);
		acc(1, 4'h0, 16'h600e);
		feed(4'h4, 4);
		acc(0, 4'h2, 16'h0008);
		acc(0, 4'h0, 16'h608e);
		chk("cfg", 16'h18, {scan, pos, neg, res, chan});
		feed(4'h4, 8);
		acc(0, 4'h0, 16'h600e);
		acc(1, 4'h0, 16'h0);
		feed(4'h3, 11);
		acc(1, 4'h1, 16'h0000);
		acc(1, 4'h0, 16'h000c);
		feed(4'h4, 15);
		foreach (want[i]) begin
			chk("dma", {want[i][4], want[i]}, seen[i]);
		end
		stall <= 1'b1;
		feed(4'hf, 0);
		for (int i = 0; i < 40 && cready; i++) @(posedge clk);
		#1 chk("ready", 16'h0, cready);
		stall <= 1'b0;
		drain(30);
		chk("count", 16'd30, seen.size());
		conclude;
	end
	initial begin
		#100000;
		err_total++;
		conclude;
	end
endmodule
